// >>> core/pts_core.sv
// PTP frame timestamping core: transmit stamping, receive stamping, register slave
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module pts_core
  import pts_pkg::*;
#(
  parameter int DLY_BYTES = 20,
  parameter bit CF_FORMAT = 1'b0
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // AXI4-Lite register slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Transmit stream and stamp return
  input  wire pts_beat_t   tx_in,
  input  wire pts_cmd_t    tx_cmd,
  input  wire logic [79:0] tx_timer,
  output logic             tx_in_ready,
  output pts_beat_t        tx_out,
  output logic             tx_ts_valid,
  output logic [15:0]      tx_ts_tag,
  output logic [79:0]      tx_ts,
  // Receive stream and stamp
  input  wire pts_beat_t   rx_in,
  input  wire logic [79:0] rx_timer,
  output pts_beat_t        rx_out,
  output logic             rx_ts_ena,
  output logic [79:0]      rx_ts
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam logic [15:0] REF_NS = 16'(DLY_BYTES * CLK_PERIOD_NS);

  // Advance a timer value by ns in the selected format; the eighths are added in the correction format only
  function automatic logic [79:0] pts_adv(input logic [79:0] t, input logic [15:0] ns,
                                          input logic [2:0] fr, input logic cf);
    logic [32:0] s;
    s = 33'(t[31:0]) + 33'(ns);
    if (cf)
      pts_adv = {16'h0000, t[63:0] + {32'h0000_0000, ns, fr, 13'h0000}};
    else if (s >= NS_PER_SEC)
      pts_adv = {t[79:32] + 48'h1, 32'(s - NS_PER_SEC)};
    else
      pts_adv = {t[79:32], s[31:0]};
  endfunction

  // Ones-complement incremental update over five 16-bit words
  function automatic logic [15:0] pts_csum(input logic [15:0] hc, input logic [79:0] mo,
                                           input logic [79:0] mn);
    logic [19:0] s;
    s = {4'h0, ~hc};
    for (int i = 0; i < 5; i++)
      s = s + {4'h0, ~mo[i*16 +: 16]} + {4'h0, mn[i*16 +: 16]};
    s = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
    s = {4'h0, s[15:0]} + {16'h0000, s[19:16]};
    pts_csum = ~s[15:0];
  endfunction

  // Reflected CRC-32 over one byte
  function automatic logic [31:0] pts_crc(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    pts_crc = r;
  endfunction

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [15:0] tx_cnt_r, rx_cnt_r;
  logic        awready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic        ose, tcm;
  logic [10:0] lat;
  assign ose = ctrl_r[CTRL_OSE_BIT];
  assign tcm = ctrl_r[CTRL_TC_BIT];
  assign lat = ctrl_r[CTRL_LAT_LSB +: 11];

  // Write: address and data taken together, one write in flight
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r    <= CTRL_RST;
      awready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      awready_r <= s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
      if (awready_r) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (s_axi_awaddr == PTS_CTRL_OFF || s_axi_awaddr == PTS_STAT_OFF)
                    ? RESP_OKAY : RESP_DECERR;
        if (s_axi_awaddr == PTS_CTRL_OFF) begin
          for (int b = 0; b < 4; b++)
            if (s_axi_wstrb[b])
              ctrl_r[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
        end
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read: status shows stamp counts from both paths
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      arready_r <= s_axi_arvalid && !arready_r && !rvalid_r;
      if (arready_r) begin
        rvalid_r <= 1'b1;
        rresp_r  <= RESP_OKAY;
        rdata_r  <= 32'h0000_0000;
        if (s_axi_araddr == PTS_CTRL_OFF)
          rdata_r <= ctrl_r;
        else if (s_axi_araddr == PTS_STAT_OFF)
          rdata_r <= {rx_cnt_r, tx_cnt_r};
        else
          rresp_r <= RESP_DECERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit input side: command capture and field sampling
  // ----------------------------------------------------------------
  pts_beat_t   dl_r [DLY_BYTES];
  pts_cmd_t    cmd_r, cc;
  logic        rdy_r, one_r, cfm_r, take, take_sop, one_en, cfm, cur_one, cur_cf;
  logic [79:0] stamp_r;
  logic [63:0] cf_old_r;
  logic [15:0] hc_r;
  logic [11:0] pin_r, ipos, icpos;
  assign take     = tx_in.vld && rdy_r;
  assign take_sop = take && tx_in.sop;
  assign one_en   = (tx_cmd.op == OP_ONE) && ose;
  assign cfm      = CF_FORMAT || tcm;
  assign cc       = tx_in.sop ? tx_cmd : cmd_r;
  assign cur_one  = tx_in.sop ? one_en : one_r;
  assign cur_cf   = tx_in.sop ? cfm : cfm_r;
  assign ipos     = tx_in.sop ? 12'h000 : pin_r;
  assign icpos    = cur_cf ? cc.stamp_off - CSUM_TO_CF : cc.csum_off;

  // Stamp taken as the start byte enters; the timer is already on this clock
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd_r   <= '0;
      one_r   <= 1'b0;
      cfm_r   <= 1'b0;
      stamp_r <= 80'h0;
    end else if (take_sop) begin
      cmd_r   <= tx_cmd;
      one_r   <= one_en;
      cfm_r   <= cfm;
      stamp_r <= one_en ? pts_adv(tx_timer, {8'h00, lat[10:3]}, lat[2:0], cfm)
                        : pts_adv(tx_timer, REF_NS, 3'h0, cfm);
    end
  end

  // Old correction field and checksum grabbed on the way in
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_r    <= 12'h000;
      cf_old_r <= 64'h0;
      hc_r     <= 16'h0000;
    end else if (take) begin
      pin_r <= ipos + 12'h001;
      if (cur_one && cur_cf && (ipos - cc.stamp_off) < CF_BYTES)
        cf_old_r <= {cf_old_r[55:0], tx_in.data};
      if (ipos == icpos)
        hc_r[15:8] <= tx_in.data;
      if (ipos == icpos + 12'h001)
        hc_r[7:0] <= tx_in.data;
    end
  end

  // Delay line gives the checksum time to see the whole correction field
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DLY_BYTES; i++)
        dl_r[i] <= '0;
    end else begin
      dl_r[0]     <= take ? tx_in : '0;
      for (int i = 1; i < DLY_BYTES; i++)
        dl_r[i] <= dl_r[i-1];
    end
  end

  // ----------------------------------------------------------------
  // Transmit output side: modification, FCS, stamp return
  // ----------------------------------------------------------------
  typedef enum logic {OS_DATA, OS_FCS} pts_ostate_t;
  pts_ostate_t os_r;
  pts_beat_t   tail, tx_out_r;
  logic [11:0] pout_r, opos, rel, ocpos;
  logic [63:0] cf_new;
  logic [15:0] hc_new;
  logic [31:0] crc_r;
  logic [1:0]  fcs_i_r;
  logic [7:0]  ob;
  logic        ts_vld_r;
  logic [15:0] ts_tag_r;
  logic [79:0] ts_r;
  assign tail   = dl_r[DLY_BYTES-1];
  assign opos   = tail.sop ? 12'h000 : pout_r;
  assign rel    = opos - cmd_r.stamp_off;
  assign ocpos  = cfm_r ? cmd_r.stamp_off - CSUM_TO_CF : cmd_r.csum_off;
  assign cf_new = cf_old_r + stamp_r[63:0];
  assign hc_new = cfm_r ? pts_csum(hc_r, {16'h0000, cf_old_r}, {16'h0000, cf_new})
                        : pts_csum(hc_r, 80'h0, stamp_r);

  // Byte replacement; two-step and plain frames fall straight through
  always_comb begin
    ob = tail.data;
    if (one_r) begin
      if (cfm_r && rel < CF_BYTES)
        ob = cf_new[(3'h7 - rel[2:0])*8 +: 8];
      else if (!cfm_r && rel < TOD_BYTES)
        ob = stamp_r[(4'h9 - rel[3:0])*8 +: 8];
      if (cmd_r.csum_upd && opos == ocpos)
        ob = hc_new[15:8];
      if (cmd_r.csum_upd && opos == ocpos + 12'h001)
        ob = hc_new[7:0];
    end
  end

  // Output bytes, then four FCS bytes over what was actually sent
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      os_r     <= OS_DATA;
      tx_out_r <= '0;
      pout_r   <= 12'h000;
      crc_r    <= 32'hFFFF_FFFF;
      fcs_i_r  <= 2'h0;
      rdy_r    <= 1'b1;
    end else begin
      tx_out_r <= '0;
      if (take && tx_in.last)
        rdy_r <= 1'b0;
      unique case (os_r)
        OS_DATA: begin
          if (tail.vld) begin
            tx_out_r <= '{data: ob, sop: tail.sop, last: 1'b0, vld: 1'b1};
            crc_r    <= pts_crc(tail.sop ? 32'hFFFF_FFFF : crc_r, ob);
            pout_r   <= opos + 12'h001;
            fcs_i_r  <= 2'h0;
            if (tail.last)
              os_r <= OS_FCS;
          end
        end
        OS_FCS: begin
          tx_out_r <= '{data: ~crc_r[fcs_i_r*8 +: 8], sop: 1'b0,
                        last: (fcs_i_r == 2'h3), vld: 1'b1};
          fcs_i_r  <= fcs_i_r + 2'h1;
          if (fcs_i_r == 2'h3) begin
            os_r  <= OS_DATA;
            rdy_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // Stamp and tag returned as the start byte leaves
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ts_vld_r <= 1'b0;
      ts_tag_r <= 16'h0000;
      ts_r     <= 80'h0;
      tx_cnt_r <= 16'h0000;
    end else begin
      ts_vld_r <= 1'b0;
      if (tail.vld && tail.sop && (cmd_r.op == OP_ONE || cmd_r.op == OP_TWO)) begin
        ts_vld_r <= 1'b1;
        ts_tag_r <= cmd_r.tag;
        ts_r     <= stamp_r;
        tx_cnt_r <= tx_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive: every start of packet stamped, no parsing
  // ----------------------------------------------------------------
  pts_beat_t   rx_out_r;
  logic        rx_ena_r;
  logic [79:0] rx_ts_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_out_r <= '0;
      rx_ena_r <= 1'b0;
      rx_ts_r  <= 80'h0;
      rx_cnt_r <= 16'h0000;
    end else begin
      rx_out_r <= rx_in;
      rx_ena_r <= rx_in.vld && rx_in.sop;
      if (rx_in.vld && rx_in.sop) begin
        rx_ts_r  <= rx_timer;
        rx_cnt_r <= rx_cnt_r + 16'h0001;
      end
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = awready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign tx_in_ready   = rdy_r;
  assign tx_out        = tx_out_r;
  assign tx_ts_valid   = ts_vld_r;
  assign tx_ts_tag     = ts_tag_r;
  assign tx_ts         = ts_r;
  assign rx_out        = rx_out_r;
  assign rx_ts_ena     = rx_ena_r;
  assign rx_ts         = rx_ts_r;

  // ----------------------------------------------------------------
  // Assertions (timings assume the default delay depth)
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_two_in;
    take_sop && tx_cmd.op == OP_TWO;
  endsequence
  sequence s_off_in;
    take_sop && (tx_cmd.op == OP_NOP || tx_cmd.op == 2'h3);
  endsequence
  sequence s_fcs_tail;
    ##1 (tx_out_r.vld && !tx_out_r.last) [*4] ##1 (tx_out_r.vld && tx_out_r.last);
  endsequence
  AST_RX_STAMP: assert property (rx_in.vld && rx_in.sop |=>
    rx_ena_r && rx_ts_r == $past(rx_timer)) else $error("rx stamp wrong");
  AST_RX_SOP: assert property (rx_ena_r |-> rx_out_r.sop && rx_out_r.vld)
    else $error("rx enable off sop");
  AST_TWO_TAG: assert property (s_two_in |-> ##21
    (ts_vld_r && ts_tag_r == $past(tx_cmd.tag, 21) && tx_out_r.data == $past(tx_in.data, 21)))
    else $error("two-step tag or data wrong");
  AST_NOP: assert property (s_off_in |-> ##21 !ts_vld_r)
    else $error("stamp on nop frame");
  AST_ONE_OFF: assert property (take_sop && tx_cmd.op == OP_ONE && !ose |-> ##21
    (tx_out_r.data == $past(tx_in.data, 21))) else $error("disabled one-step modified");
  AST_GATE: assert property (take_sop && !ose |=> !one_r)
    else $error("one-step while disabled");
  AST_CF_TOP: assert property (ts_vld_r && cfm_r |-> ts_r[79:64] == 16'h0000)
    else $error("cf stamp upper bits set");
  AST_FCS: assert property (os_r == OS_DATA && tail.vld && tail.last |->
    s_fcs_tail)
    else $error("fcs bytes wrong");
endmodule

// >>> core/pts_pkg.sv
// Shared constants and types for the PTP frame timestamping core
package pts_pkg;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  PTS_CTRL_OFF   = 4'h0;
  localparam logic [3:0]  PTS_STAT_OFF   = 4'h4;
  localparam int          CTRL_OSE_BIT   = 0;
  localparam int          CTRL_TC_BIT    = 1;
  localparam int          CTRL_LAT_LSB   = 8;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;
  // ----------------------------------------------------------------
  // Stamp opcodes, frame layout and timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  OP_NOP         = 2'h0;
  localparam logic [1:0]  OP_ONE         = 2'h1;
  localparam logic [1:0]  OP_TWO         = 2'h2;
  localparam logic [11:0] CSUM_TO_CF     = 12'h00A;
  localparam logic [11:0] CF_BYTES       = 12'h008;
  localparam logic [11:0] TOD_BYTES      = 12'h00A;
  localparam logic [32:0] NS_PER_SEC     = 33'h0_3B9A_CA00;
  localparam logic [31:0] CRC_POLY       = 32'hEDB8_8320;
  localparam int          CLK_PERIOD_NS  = 40;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       sop;
    logic       last;
    logic       vld;
  } pts_beat_t;
  typedef struct packed {
    logic [1:0]  op;
    logic        csum_upd;
    logic [15:0] tag;
    logic [11:0] stamp_off;
    logic [11:0] csum_off;
  } pts_cmd_t;
endpackage

// >>> testbench/pts_client.sv
// Client packet source model feeding the transmit stream of the core
`timescale 1ns/1ns
module pts_client
  import pts_pkg::*;
(
  // Clock and stream handshake
  input  wire logic       clock,
  input  wire logic       tx_in_ready,
  // Frame bytes and per-frame command
  output pts_beat_t       tx_in,
  output pts_cmd_t        tx_cmd
);
  // ----------------------------------------------------------------
  // Idle lines at time zero
  // ----------------------------------------------------------------
  initial begin
    tx_in = '0;
    tx_cmd = '0;
  end

  // ----------------------------------------------------------------
  // Frame sender, optional stalls between bytes
  // ----------------------------------------------------------------
  // Command is valid on the first byte only; later bytes carry its inverse
  task automatic send(input pts_cmd_t cmd, input int len, input int gap);
    @(posedge clock);
    while (tx_in_ready !== 1'b1) @(posedge clock);
    for (int i = 0; i < len; i++) begin
      tx_in <= {8'(i + 16), i == 0, i == len - 1, 1'b1};
      tx_cmd <= (i == 0) ? cmd : ~cmd;
      do @(posedge clock); while (tx_in_ready !== 1'b1);
      // Released data shows inverted bytes so stale values never match
      if (gap > 0 || i == len - 1) begin
        tx_in <= {~tx_in.data, 3'b000};
        repeat (gap) @(posedge clock);
      end
    end
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking testbench for the timestamping core
`timescale 1ns/1ns
module tb;
  import pts_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus constants
  // ----------------------------------------------------------------
  localparam int         FR_LEN = 24;
  localparam logic [79:0] TMR    = {48'h0000_0000_1234, 32'h0000_1000};
  localparam logic [79:0] RX_TMR = {48'h0000_0000_0777, 32'h0000_2222};
  // Latency adjust 43 is 5 ns plus 3/8 ns; the fraction is dropped
  localparam logic [79:0] ONE_TS = {48'h0000_0000_1234, 32'h0000_1005};
  localparam logic [79:0] TWO_TS = {48'h0000_0000_1234, 32'h0000_1320};
  // Latency adjust 471 is 58 7/8 ns, scaled by two to the sixteenth; top 16 bits zero
  localparam logic [79:0] CF_TS  = {16'h0000, 64'h0000_1234_003A_F000};

  logic        clock, rst_b;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, tx_in_ready, tx_ts_valid, rx_ts_ena;
  pts_beat_t   tx_in, tx_out, rx_in, rx_out;
  pts_cmd_t    tx_cmd;
  logic [79:0] tx_timer, rx_timer, tx_ts, rx_ts, ts_seen;
  logic [15:0] tx_ts_tag, tag_seen;
  logic [7:0]  out_q[$];
  int          failures, tests_run, ts_cnt, cycles;

  pts_core #(.DLY_BYTES(20), .CF_FORMAT(1'b0)) dut (
    .clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_in, .tx_cmd, .tx_timer,
    .tx_in_ready, .tx_out, .tx_ts_valid, .tx_ts_tag, .tx_ts, .rx_in, .rx_timer,
    .rx_out, .rx_ts_ena, .rx_ts);
  pts_client client (.clock, .tx_in_ready, .tx_in, .tx_cmd);

  // ----------------------------------------------------------------
  // Clock, timeout and output monitor
  // ----------------------------------------------------------------
  initial clock = 1'b0;
  always #20 clock = ~clock;
  // A hang anywhere ends the run as a failure
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  always @(posedge clock) begin
    if (tx_out.vld === 1'b1) out_q.push_back(tx_out.data);
    if (tx_ts_valid === 1'b1) begin
      ts_cnt++;
      ts_seen = tx_ts;
      tag_seen = tx_ts_tag;
      check(80'(tx_out.sop), 80'h1);
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge clock);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clock);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  // Reflected CRC-32 with all-ones start, complemented at the end
  function automatic logic [31:0] crc32(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    foreach (b[i]) begin
      c = c ^ {24'h0, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  // Ones-complement sum with end-around carry
  function automatic logic [15:0] oc_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + 16'(s[16]);
  endfunction
  // Send one frame and judge bytes, check sequence and returned stamp;
  // mode 0 leaves it alone, 1 inserts a time-of-day stamp, 2 sums a correction field
  task automatic tx_frame(input logic [1:0] op, input int gap, input logic [79:0] ets,
                          input int mode);
    logic [7:0]  exp_q[$];
    logic [31:0] fcs;
    logic [79:0] old_f, new_f;
    logic [15:0] hc;
    int          spos, cpos, nb;
    pts_cmd_t    cmd;
    spos = (mode == 2) ? 12 : 4;
    cpos = (mode == 2) ? spos - int'(CSUM_TO_CF) : 0;
    nb = (mode == 2) ? 8 : 10;
    cmd = '{op, mode != 0, 16'(gap + 16'h0C00), 12'(spos), 12'h000};
    out_q = {};
    ts_cnt = 0;
    old_f = 80'h0;
    for (int i = 0; i < FR_LEN; i++) exp_q.push_back(8'(i + 16));
    if (mode == 2) begin
      for (int i = 0; i < 8; i++) old_f = {old_f[71:0], exp_q[spos + i]};
    end
    new_f = (mode == 2) ? {16'h0000, old_f[63:0] + ets[63:0]} : ets;
    // Checksum patched incrementally: old word out, new word in
    if (mode != 0) begin
      hc = ~{exp_q[cpos], exp_q[cpos + 1]};
      for (int i = 0; i < 5; i++) begin
        hc = oc_add(oc_add(hc, ~old_f[16 * i +: 16]), new_f[16 * i +: 16]);
      end
      for (int i = 0; i < nb; i++) exp_q[spos + i] = new_f[8 * nb - 1 - 8 * i -: 8];
      exp_q[cpos] = ~hc[15:8];
      exp_q[cpos + 1] = ~hc[7:0];
    end
    fcs = crc32(exp_q);
    for (int i = 0; i < 4; i++) exp_q.push_back(fcs[8 * i +: 8]);
    client.send(cmd, FR_LEN, gap);
    for (int k = 0; k < 200 && out_q.size() < FR_LEN + 4; k++) @(posedge clock);
    repeat (3) @(posedge clock);
    check(80'(out_q.size()), 80'(FR_LEN + 4));
    foreach (exp_q[i]) check(80'(out_q[i]), 80'(exp_q[i]));
    check(80'(ts_cnt), 80'(op == OP_ONE || op == OP_TWO));
    if (op == OP_ONE || op == OP_TWO) begin
      check(80'(tag_seen), 80'(cmd.tag));
      check(ts_seen, ets);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reg_test();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(PTS_CTRL_OFF, d, r);
    check(80'(d), 80'(CTRL_RST));
    axi_wr(PTS_STAT_OFF, 32'hFFFF_FFFF, r);
    check(80'(r), 80'(RESP_OKAY));
    axi_rd(PTS_STAT_OFF, d, r);
    check(80'(d), 80'h0);
    axi_wr(4'h8, 32'h0000_0001, r);
    check(80'(r), 80'(RESP_DECERR));
    axi_rd(4'hC, d, r);
    check(80'({r, d}), 80'({RESP_DECERR, 32'h0}));
    $display("test reg_test done");
  endtask
  // One-step command while disabled: frame untouched, stamp at the reference plane
  task automatic one_step_off();
    logic [1:0] r;
    axi_wr(PTS_CTRL_OFF, 32'h0000_2B00, r);
    tx_frame(OP_ONE, 1, TWO_TS, 0);
    $display("test one_step_off done");
  endtask
  // Transparent one-step: stamp summed into the correction field, checksum patched
  task automatic cf_one_step();
    logic [1:0] r;
    axi_wr(PTS_CTRL_OFF, 32'h0001_D703, r);
    tx_frame(OP_ONE, 0, CF_TS, 2);
    $display("test cf_one_step done");
  endtask
  // Every opcode with one-step enabled, growing stalls from the client
  task automatic op_sweep();
    logic [1:0] ops[4] = '{OP_NOP, OP_TWO, 2'h3, OP_ONE};
    logic [1:0] r;
    axi_wr(PTS_CTRL_OFF, 32'h0000_2B01, r);
    foreach (ops[i]) tx_frame(ops[i], i, ops[i] == OP_ONE ? ONE_TS : TWO_TS, ops[i] == OP_ONE);
    $display("test op_sweep done");
  endtask
  task automatic rx_test();
    pts_beat_t b, prev;
    for (int i = 0; i < 4; i++) begin
      b = {8'(i + 8'hA0), i == 0, i == 2, 1'b1};
      if (i == 3) b = {~8'hA2, 3'b000};
      @(posedge clock);
      rx_in <= b;
      #1;
      if (i > 0) begin
        check(80'(rx_out), 80'(prev));
        check(80'(rx_ts_ena), 80'(i == 1));
        if (i == 1) check(rx_ts, RX_TMR);
      end
      prev = b;
    end
    $display("test rx_test done");
  endtask
  // Stamp counters: four transmit stamps, one receive stamp
  task automatic status_test();
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clock);
    axi_rd(PTS_STAT_OFF, d, r);
    check(80'(d), 80'h0001_0004);
    $display("test status_test done");
  endtask
  task automatic finish_test();
    $display("tests_run %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    rst_b = 1'b0;
    rx_in = '0;
    tx_timer = TMR;
    rx_timer = RX_TMR;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    reg_test();
    one_step_off();
    op_sweep();
    cf_one_step();
    rx_test();
    status_test();
    finish_test();
  end
endmodule
